// >>> verilog/asbl_pkg.sv
// package for the async sram byte-lane host controller
package asbl_pkg;
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned ADDR_W = 17;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned BYTE_W = 8;
	// timing figures in picoseconds
	localparam int unsigned WRITE_CYCLE_MIN_PS = 10000;
	localparam int unsigned WRITE_PULSE_MIN_PS = 7000;
	localparam int unsigned WRITE_DATA_SETUP_PS = 5000;
	localparam int unsigned WRITE_LOW_FLOAT_DELAY_PS = 5000;
	localparam int unsigned READ_CYCLE_MIN_PS = 10000;
	localparam int unsigned ADDRESS_ACCESS_DELAY_PS = 10000;
	localparam int unsigned OE_FLOAT_DELAY_PS = 5000;
	// least times round up
	localparam int unsigned WR_PULSE_CYC =
		(WRITE_PULSE_MIN_PS + WRITE_LOW_FLOAT_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned WR_CYCLE_CYC =
		(WRITE_CYCLE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned RD_ACCESS_CYC =
		(ADDRESS_ACCESS_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned TURN_CYC =
		(OE_FLOAT_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int unsigned CNT_W = 4;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [1:0] LANES_OFF = 2'h0;

	typedef struct packed {
		logic write;
		logic [1:0] lanes;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} asbl_req_t;

	typedef struct packed {
		logic chip_sel_n;
		logic out_en_n;
		logic write_en_n;
		logic low_byte_lane_enable_n;
		logic high_byte_lane_enable_n;
	} asbl_ctl_t;

	localparam asbl_ctl_t CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

	typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR_SETUP, ST_WR, ST_WR_END, ST_GAP} asbl_state_t;
endpackage

// >>> verilog/asbl_ctrl.sv
// host controller driving an asynchronous 16-bit byte-lane sram
`timescale 1ns/100ps
`default_nettype none
module asbl_ctrl
	import asbl_pkg::*;
(
	input wire logic SYS_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic REQ_VALID_IN,
	input wire asbl_req_t REQ_IN,
	output logic REQ_READY_OUT,
	output logic RSP_VALID_OUT,
	output logic [DATA_W-1:0] RSP_DATA_OUT,
	output asbl_ctl_t MEM_CTL_OUT,
	output logic [ADDR_W-1:0] MEM_ADDR_OUT,
	input wire logic [DATA_W-1:0] MEM_DQ_IN,
	output logic [DATA_W-1:0] MEM_DQ_OUT,
	output logic [1:0] MEM_DQ_OE_OUT
);
	// --------------------------------------------------
	// state and registers
	// --------------------------------------------------
	asbl_state_t state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	asbl_ctl_t ctl_ff, nxt_ctl;
	logic [ADDR_W-1:0] addr_ff, nxt_addr;
	logic [DATA_W-1:0] wdata_ff, nxt_wdata;
	logic [1:0] oe_ff, nxt_oe;
	logic [1:0] lanes_ff, nxt_lanes;
	logic ready_ff, nxt_ready;
	logic rsp_valid_ff, nxt_rsp_valid;
	logic [DATA_W-1:0] rsp_data_ff, nxt_rsp_data;
	logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff;

	wire take = REQ_VALID_IN && ready_ff && (REQ_IN.lanes != LANES_OFF);
	wire cnt_done = (cnt_ff == CNT_ZERO);
	wire [CNT_W-1:0] cnt_dec = cnt_ff - CNT_ONE;

	// lane-select data mask, reads return zero on unused lanes
	function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] lanes);
		lane_mask = {{BYTE_W{lanes[1]}}, {BYTE_W{lanes[0]}}};
	endfunction

	// --------------------------------------------------
	// next state
	// --------------------------------------------------
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_done ? cnt_ff : cnt_dec;
		nxt_ctl = ctl_ff;
		nxt_addr = addr_ff;
		nxt_wdata = wdata_ff;
		nxt_oe = oe_ff;
		nxt_lanes = lanes_ff;
		nxt_ready = ready_ff;
		nxt_rsp_valid = 1'b0;
		nxt_rsp_data = rsp_data_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (take) begin
					nxt_ready = 1'b0;
					nxt_addr = REQ_IN.addr;
					nxt_wdata = REQ_IN.wdata;
					nxt_lanes = REQ_IN.lanes;
					nxt_ctl.chip_sel_n = 1'b0;
					nxt_ctl.low_byte_lane_enable_n = ~REQ_IN.lanes[0];
					nxt_ctl.high_byte_lane_enable_n = ~REQ_IN.lanes[1];
					if (REQ_IN.write) begin
						// address settles one cycle before write enable
						nxt_state = ST_WR_SETUP;
					end else begin
						nxt_ctl.out_en_n = 1'b0;
						nxt_cnt = CNT_W'(RD_ACCESS_CYC + 1);
						nxt_state = ST_RD;
					end
				end
			end
			ST_RD: begin
				// extra cycle covers the two-stage input sync
				if (cnt_done) begin
					nxt_rsp_valid = 1'b1;
					nxt_rsp_data = dq_s2_ff & lane_mask(lanes_ff);
					nxt_ctl = CTL_IDLE;
					nxt_cnt = CNT_W'(TURN_CYC);
					nxt_state = ST_GAP;
				end
			end
			ST_WR_SETUP: begin
				nxt_ctl.write_en_n = 1'b0;
				nxt_oe = lanes_ff;
				nxt_cnt = CNT_W'(WR_PULSE_CYC - 1);
				nxt_state = ST_WR;
			end
			ST_WR: begin
				// pulse spans minimum pulse width plus float delay
				if (cnt_done) begin
					nxt_ctl.write_en_n = 1'b1;
					nxt_state = ST_WR_END;
				end
			end
			ST_WR_END: begin
				// data and address held past the terminating edge
				nxt_oe = LANES_OFF;
				nxt_ctl = CTL_IDLE;
				nxt_cnt = CNT_W'(TURN_CYC);
				nxt_state = ST_GAP;
			end
			ST_GAP: begin
				if (cnt_done) begin
					nxt_ready = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_ctl = CTL_IDLE;
				nxt_oe = LANES_OFF;
				nxt_ready = 1'b1;
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// --------------------------------------------------
	// registers
	// --------------------------------------------------
	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			state_ff <= ST_IDLE;
			cnt_ff <= CNT_ZERO;
			ctl_ff <= CTL_IDLE;
			addr_ff <= '0;
			wdata_ff <= '0;
			oe_ff <= LANES_OFF;
			lanes_ff <= LANES_OFF;
			ready_ff <= 1'b1;
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= '0;
			dq_s1_ff <= '0;
			dq_s2_ff <= '0;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			ctl_ff <= nxt_ctl;
			addr_ff <= nxt_addr;
			wdata_ff <= nxt_wdata;
			oe_ff <= nxt_oe;
			lanes_ff <= nxt_lanes;
			ready_ff <= nxt_ready;
			rsp_valid_ff <= nxt_rsp_valid;
			rsp_data_ff <= nxt_rsp_data;
			dq_s1_ff <= MEM_DQ_IN;
			dq_s2_ff <= dq_s1_ff;
		end
	end

	assign REQ_READY_OUT = ready_ff;
	assign RSP_VALID_OUT = rsp_valid_ff;
	assign RSP_DATA_OUT = rsp_data_ff;
	assign MEM_CTL_OUT = ctl_ff;
	assign MEM_ADDR_OUT = addr_ff;
	assign MEM_DQ_OUT = wdata_ff;
	assign MEM_DQ_OE_OUT = oe_ff;

	// --------------------------------------------------
	// assertions
	// --------------------------------------------------
	default clocking cb @(posedge SYS_CLK_IN); endclocking
	default disable iff (!ARST_N_IN);

	sequence s_we_fall;
		$fell(ctl_ff.write_en_n);
	endsequence
	sequence s_we_pulse;
		!ctl_ff.write_en_n [*3];
	endsequence
	sequence s_we_rise;
		$rose(ctl_ff.write_en_n);
	endsequence

	a_host_no_clash: assert property (|oe_ff |-> ctl_ff.out_en_n)
		else $error("host drives data while output enable low");
	a_drive_only_write: assert property (|oe_ff |-> !ctl_ff.write_en_n || !$past(ctl_ff.write_en_n))
		else $error("host drives data outside write");
	a_write_overlap: assert property (!ctl_ff.write_en_n |-> !ctl_ff.chip_sel_n
		&& (!ctl_ff.low_byte_lane_enable_n || !ctl_ff.high_byte_lane_enable_n))
		else $error("write enable without select and lane");
	a_we_pulse_width: assert property (s_we_fall |-> s_we_pulse)
		else $error("write pulse shorter than minimum");
	a_data_hold: assert property ($rose(ctl_ff.write_en_n) |-> oe_ff != LANES_OFF
		&& $stable(addr_ff) && $stable(wdata_ff))
		else $error("data or address not held at write end");
	a_addr_stable: assert property (!ctl_ff.write_en_n |-> $stable(addr_ff))
		else $error("address moved during write");
	a_addr_setup: assert property (s_we_fall |-> !$past(ctl_ff.chip_sel_n))
		else $error("address and select not set before write");
	a_write_gap: assert property ($rose(ctl_ff.write_en_n) |-> ctl_ff.write_en_n [*3])
		else $error("writes too close together");
	a_read_length: assert property ($fell(ctl_ff.out_en_n) |-> !ctl_ff.out_en_n [*4])
		else $error("read cycle too short");
	a_read_resp: assert property ($fell(ctl_ff.out_en_n) |-> ##[4:6] rsp_valid_ff)
		else $error("read answer not on time");
	a_read_no_write: assert property (!ctl_ff.out_en_n |-> ctl_ff.write_en_n)
		else $error("output enable and write enable low together");
	a_data_setup: assert property (s_we_rise |-> $past(oe_ff, 2) == lanes_ff)
		else $error("write data not driven before write end");
	a_low_lane: assert property (!ctl_ff.chip_sel_n |->
		ctl_ff.low_byte_lane_enable_n != lanes_ff[0])
		else $error("low lane enable differs from request");
	a_high_lane: assert property (!ctl_ff.chip_sel_n |->
		ctl_ff.high_byte_lane_enable_n != lanes_ff[1])
		else $error("high lane enable differs from request");
	a_rsp_idle: assert property (rsp_valid_ff |-> ctl_ff == CTL_IDLE)
		else $error("read answer while memory still selected");
	a_rsp_pulse: assert property (rsp_valid_ff |=> !rsp_valid_ff)
		else $error("read answer longer than one cycle");
	a_idle_quiet: assert property (state_ff == ST_IDLE |->
		ctl_ff == CTL_IDLE && oe_ff == LANES_OFF)
		else $error("memory pins active while idle");
	a_turn_gap: assert property ($rose(ready_ff) |-> ctl_ff.chip_sel_n
		&& $past(ctl_ff.chip_sel_n) && $past(ctl_ff.chip_sel_n, 2))
		else $error("new access without turnaround gap");
	a_read_addr_hold: assert property (!ctl_ff.out_en_n && !$past(ctl_ff.out_en_n) |->
		$stable(addr_ff))
		else $error("address moved during read");
	a_no_empty_take: assert property (REQ_VALID_IN && ready_ff && REQ_IN.lanes == LANES_OFF
		|=> ready_ff)
		else $error("request without lanes was taken");
endmodule
`default_nettype wire

// >>> test/asbl_sram_model.sv
// behavioural async byte-lane sram answering the host controller
`timescale 1ns/100ps
`default_nettype none
module asbl_sram_model
	import asbl_pkg::*;
#(
	parameter int ACC_NS = 10
) (
	input wire asbl_ctl_t ctl_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] dq_in,
	input wire logic [1:0] dq_oe_in,
	output logic [DATA_W-1:0] dq_out
);
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	logic [DATA_W-1:0] rd;
	logic tog = 1'b0;
	wire sel = !ctl_in.chip_sel_n;
	wire [1:0] lane = ~{ctl_in.high_byte_lane_enable_n, ctl_in.low_byte_lane_enable_n};
	wire rd_act = sel && !ctl_in.out_en_n && ctl_in.write_en_n;
	wire [1:0] md = rd_act ? lane : 2'h0;
	wire wr_act = sel && !ctl_in.write_en_n && lane != 2'h0;
	// undriven lanes wander so a stale value never passes
	initial forever #3 tog = ~tog;
	always @(addr_in or ctl_in) rd <= #(ACC_NS) mem[addr_in];
	for (genvar b = 0; b < 2; b++) begin : g_lane
		assign dq_out[b*8+:8] = (dq_oe_in[b] && md[b]) ? 8'hxx :
			dq_oe_in[b] ? dq_in[b*8+:8] : md[b] ? rd[b*8+:8] : {8{tog}} ^ 8'h5a;
	end
	always @(wr_act or dq_out or addr_in or lane) begin
		if (wr_act) begin
			if (lane[0]) mem[addr_in][7:0] = dq_out[7:0];
			if (lane[1]) mem[addr_in][15:8] = dq_out[15:8];
		end
	end
endmodule
`default_nettype wire

// >>> test/async_sram_byte_lane_access_tb.sv
// self-checking bench for the async sram host controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin failures++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end
module async_sram_byte_lane_access_tb
	import asbl_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic vld = 1'b0;
	logic rdy, rsp;
	asbl_req_t req = '0;
	asbl_ctl_t ctl;
	logic [DATA_W-1:0] rdat, dqo, dqi;
	logic [ADDR_W-1:0] addr;
	logic [1:0] oe;
	int failures = 0;
	int n_tests = 0;
	int wlo = 0;
	int pool [4] = '{0, 1, 2, 'h1ffff};
	logic [DATA_W-1:0] ref_mem [int];
	asbl_ctrl i_asbl_ctrl (.SYS_CLK_IN(clk), .ARST_N_IN(rst_n), .REQ_VALID_IN(vld),
		.REQ_IN(req), .REQ_READY_OUT(rdy), .RSP_VALID_OUT(rsp), .RSP_DATA_OUT(rdat),
		.MEM_CTL_OUT(ctl), .MEM_ADDR_OUT(addr), .MEM_DQ_IN(dqi), .MEM_DQ_OUT(dqo),
		.MEM_DQ_OE_OUT(oe));
	asbl_sram_model #(.ACC_NS(10)) i_asbl_sram_model (.ctl_in(ctl), .addr_in(addr),
		.dq_in(dqo), .dq_oe_in(oe), .dq_out(dqi));
	initial forever #2 clk = ~clk;
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic op(input logic w, input logic [1:0] ln, input int a, input logic [15:0] d);
		int n;
		logic [15:0] e;
		n = 0;
		while (rdy !== 1'b1 && n < 50) begin @(negedge clk); n++; end
		vld = 1'b1;
		req = '{w, ln, a[ADDR_W-1:0], d};
		@(negedge clk);
		vld = 1'b0;
		`CHK("rdy_busy", 1'b0, rdy)
		e = ref_mem[a];
		n = 0;
		if (w) begin
			for (int b = 0; b < 2; b++) if (ln[b]) e[b*8+:8] = d[b*8+:8];
			ref_mem[a] = e;
		end else begin
			while (rsp !== 1'b1 && n < 70) begin @(negedge clk); n++; end
			// access wait, then sync flop and answer flop
			`CHK("rd_lat", int'(RD_ACCESS_CYC) + 2, n)
			for (int b = 0; b < 2; b++) if (!ln[b]) e[b*8+:8] = 8'h00;
			`CHK("rd_data", e, rdat)
		end
	endtask
	always @(negedge clk) begin
		if (rst_n && oe !== 2'h0) `CHK("oe_rd_clash", 1'b1, ctl.out_en_n)
		if (ctl.write_en_n === 1'b0) `CHK("wr_sel", 1'b0, ctl.chip_sel_n)
		if (ctl.write_en_n === 1'b0) wlo++;
		else if (wlo != 0) begin
			`CHK("we_pulse", 1, int'(wlo >= 2))
			wlo = 0;
		end
	end
	initial begin
		#100000;
		failures++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(1526));
		repeat (20) @(posedge clk);
		@(negedge clk);
		`CHK("rst_ctl", CTL_IDLE, ctl)
		`CHK("rst_oe", 2'h0, oe)
		rst_n = 1'b1;
		$display("test reset done");
		for (int a = 0; a < 4; a++) op(1'b1, 2'h3, pool[a], 16'($urandom));
		for (int ln = 1; ln < 4; ln++) begin
			op(1'b1, 2'(ln), pool[ln], 16'($urandom));
			for (int r = 1; r < 4; r++) op(1'b0, 2'(r), pool[ln], 16'h0000);
		end
		$display("test lanes done");
		repeat (60) op(1'($urandom), 2'($urandom_range(1, 3)),
			pool[$urandom_range(0, 3)], 16'($urandom));
		$display("test random done");
		while (rdy !== 1'b1) @(negedge clk);
		vld = 1'b1;
		req = '{1'b1, 2'h0, pool[0][ADDR_W-1:0], 16'hffff};
		repeat (10) begin
			@(negedge clk);
			`CHK("lane0_idle", CTL_IDLE, ctl)
		end
		vld = 1'b0;
		@(negedge clk);
		op(1'b0, 2'h3, pool[0], 16'h0000);
		$display("test no lane done");
		tally_and_finish;
	end
endmodule
`default_nettype wire
